// file: tb/tb.sv
// self-checking bench for the configuration unit event counters
`timescale 1ns/1ps
module tb;
   localparam int CW = 6;  // short counters so wrap is reached quickly
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   logic        msr_wr = 1'b0;
   logic        msr_rd = 1'b0;
   logic [15:0] msr_addr = 16'h0000;
   logic [63:0] msr_wdata = 64'h0000000000000000;
   logic        global_en = 1'b0;
   logic [63:0] msr_rdata;
   logic        msr_rd_valid;
   logic        msr_fault;
   logic [4:0]  msg_events;
   logic        lock_start;
   int          bad_count = 0;
   int          checks_done = 0;
   logic [64:0] exp_q [$];
   logic [4:0]  mp [26];
   logic        lp [26];
   logic [31:0] w;
   logic [15:0] adr [7] = '{16'h0C08, 16'h0C09, 16'h0C10, 16'h0C11, 16'h0C16, 16'h0C17, 16'h0C12};
   // counter setups: threshold, invert, enable, edge, subevents, code
   logic [31:0] cfg [9] = '{32'h01400142, 32'h01441E42, 32'h01C41F42, 32'h01C00442,
                            32'h01400044, 32'h01401F00, 32'h00401F42, 32'h02401F42,
                            32'h01001F42};

   // ==========================================================
   // clock and design
   always #25 sys_clk = ~sys_clk;

   ucfg_event_counters #(.CNT_W(CW)) ucfg_event_counters_i (
      .sys_clk(sys_clk), .rst(rst), .msr_wr(msr_wr), .msr_rd(msr_rd),
      .msr_addr(msr_addr), .msr_wdata(msr_wdata), .msr_rdata(msr_rdata),
      .msr_rd_valid(msr_rd_valid), .msr_fault(msr_fault), .global_en(global_en),
      .msg_events(msg_events), .lock_start(lock_start));

   ucfg_event_source ucfg_event_source_i (
      .sys_clk(sys_clk), .msg_events(msg_events), .lock_start(lock_start));

   // ==========================================================
   // register access, one edge taken plus one idle edge
   task automatic wr(input logic [15:0] a, input logic [63:0] d);
      msr_wr <= 1'b1;
      msr_addr <= a;
      msr_wdata <= d;
      @(posedge sys_clk);
      msr_wr <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic rd(input logic [15:0] a, input logic [63:0] e, input logic f);
      msr_rd <= 1'b1;
      msr_addr <= a;
      exp_q.push_back({f, e});
      @(posedge sys_clk);
      msr_rd <= 1'b0;
      @(posedge sys_clk);
   endtask

   // expected count over the 26 sampled slots of one burst
   function automatic logic [63:0] exp_cnt(input logic [31:0] c);
      logic ge;
      logic prev;
      logic inc;
      logic ok;
      int   n;
      prev = 1'b0;
      n = 0;
      ok = (c[7:0] == ucfg_pkg::EV_LEGACY_WIRE_MESSAGES) || (c[7:0] == ucfg_pkg::EV_LOCK_STARTS);
      for (int j = 0; j < 26; j++) begin
         inc = (c[7:0] == ucfg_pkg::EV_LEGACY_WIRE_MESSAGES) ? |(mp[j] & c[12:8]) :
               ((c[7:0] == ucfg_pkg::EV_LOCK_STARTS) && lp[j]);
         ge = {4'h0, inc} >= c[28:24];
         if (c[22] && ok) begin
            n += c[18] ? (c[23] ? int'(prev && !ge) : int'(ge && !prev)) : int'(ge ^ c[23]);
         end
         prev = ge;
      end
      return 64'(n) & ((64'h1 << CW) - 64'h1);
   endfunction

   task automatic report_and_stop();
      if (bad_count == 0 && checks_done > 0 && exp_q.size() == 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // ==========================================================
   // answer monitor: each valid read takes the oldest note
   always @(negedge sys_clk) begin
      if (msr_rd_valid === 1'b1 || msr_fault === 1'b1) begin
         checks_done++;
         if (exp_q.size() == 0) begin
            bad_count++;
            $display("CHECK FAILED rdata expected none seen %h", msr_rdata);
         end else if ({msr_rd_valid, msr_fault, msr_rdata} !== {1'b1, exp_q[0]}) begin
            bad_count++;
            $display("CHECK FAILED rdata expected %h seen %h", exp_q[0],
                     {msr_fault, msr_rdata});
            void'(exp_q.pop_front());
         end else begin
            void'(exp_q.pop_front());
         end
      end
   end

   // watchdog against a hang
   initial begin
      repeat (4000) @(posedge sys_clk);
      bad_count++;
      $display("CHECK FAILED watchdog expected done seen running");
      report_and_stop();
   end

   // ==========================================================
   // main sequence
   initial begin
      void'($urandom(32'h67e8970b));
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      // reset values, then an unmapped address
      for (int i = 0; i < 7; i++) rd(adr[i], 64'h0, i == 6);
      // reserved and clear bits dropped, reserved 21:20 kept zero
      for (int i = 0; i < 2; i++) begin
         w = $urandom & 32'hFFCFFFFF;
         wr(ucfg_pkg::ADDR_CTL0 + 16'(i), {$urandom, w});
         rd(ucfg_pkg::ADDR_CTL0 + 16'(i), {32'h0, w & ucfg_pkg::CTL_RW_MASK}, 1'b0);
      end
      w = $urandom & 32'hFFCFFFFF;
      wr(ucfg_pkg::ADDR_FIX_CTL, {$urandom, w});
      rd(ucfg_pkg::ADDR_FIX_CTL, {32'h0, w & ucfg_pkg::FIX_CTL_RW_MASK}, 1'b0);
      // every setup on both counters, cleared on enable
      for (int k = 0; k < 9; k++) begin
         for (int i = 0; i < 2; i++) begin
            for (int j = 0; j < 26; j++) begin
               mp[j] = (j == 0 || j == 25) ? 5'h00 : 5'($urandom_range(31, 0));
               lp[j] = (j == 0 || j == 25) ? 1'b0 : 1'($urandom_range(1, 0));
            end
            wr(ucfg_pkg::ADDR_CTL0 + 16'(i), {32'h0, cfg[k] | 32'h00020000});
            ucfg_event_source_i.play(mp, lp);
            wr(ucfg_pkg::ADDR_CTL0 + 16'(i), {32'h0, cfg[k] & 32'hFFBFFFFF});
            rd(ucfg_pkg::ADDR_CTR0 + 16'(i), exp_cnt(cfg[k]), 1'b0);
         end
      end
      // counter one starts three below the top, counts five cycles, wraps to one
      wr(ucfg_pkg::ADDR_CTR1, 64'hFFFFFFFFFFFFFFFC);
      wr(ucfg_pkg::ADDR_CTL1, 64'h0000000000401F42);
      repeat (3) @(posedge sys_clk);
      wr(ucfg_pkg::ADDR_CTL1, 64'h0000000000001F42);
      rd(ucfg_pkg::ADDR_CTR1, 64'h0000000000000001, 1'b0);
      // fixed counter: read while running, then wrap past 2**CW
      global_en <= 1'b1;
      wr(ucfg_pkg::ADDR_FIX_CTL, 64'h0);
      wr(ucfg_pkg::ADDR_FIX_CTR, 64'h0);
      wr(ucfg_pkg::ADDR_FIX_CTL, 64'h0000000000400000);
      repeat (8) @(posedge sys_clk);
      rd(ucfg_pkg::ADDR_FIX_CTR, 64'h9, 1'b0);
      repeat (57) @(posedge sys_clk);
      wr(ucfg_pkg::ADDR_FIX_CTL, 64'h0);
      rd(ucfg_pkg::ADDR_FIX_CTR, 64'h5, 1'b0);
      // no count without the global enable
      global_en <= 1'b0;
      wr(ucfg_pkg::ADDR_FIX_CTR, 64'h0);
      wr(ucfg_pkg::ADDR_FIX_CTL, 64'h0000000000400000);
      repeat (10) @(posedge sys_clk);
      wr(ucfg_pkg::ADDR_FIX_CTL, 64'h0);
      rd(ucfg_pkg::ADDR_FIX_CTR, 64'h0, 1'b0);
      repeat (4) @(posedge sys_clk);
      report_and_stop();
   end
endmodule

// file: tb/ucfg_event_source.sv
// model of the message and lock event sources feeding the counters
`timescale 1ns/1ps
module ucfg_event_source (
   input  wire logic       sys_clk,     // fabric_clock
   output logic      [4:0] msg_events,  // message received pulses
   output logic            lock_start   // lock sequence start pulse
);
   // ==========================================================
   // sources idle low between bursts
   initial begin
      msg_events = 5'h00;
      lock_start = 1'b0;
   end

   // ==========================================================
   // play one burst, one pattern entry per cycle, slots 1 to 24
   task automatic play(input logic [4:0] m [26], input logic l [26]);
      for (int i = 1; i < 25; i++) begin
         msg_events <= m[i];  // one bit per type, at most one step each
         lock_start <= l[i];
         @(posedge sys_clk);
      end
      msg_events <= 5'h00;
      lock_start <= 1'b0;
   endtask
endmodule

// file: verilog/ucfg_event_counters.sv
// two programmable event counters and a fixed cycle counter
//
// Behaviour
// - threshold field at bits 28:24 is compared with each cycle's increment.
// - bit 23 flips compare: clear means increment >= threshold, set means below.
// - bit 18 set counts rising transitions; clear counts every asserted cycle.
// - edge and invert both set counts falling transitions instead.
// - writing one to write-only bit 17 clears the paired data counter.
// - bits 7:0 select event code, bits 15:8 select its subevents.
// - each data counter holds 44 bits; bits 63:44 reserved, reset zero.
// - carry out of bit 43 wraps the counter, counting continues.
// - data counters may be read at any time while counting.
// - fixed counter adds one each fabric clock cycle while enabled.
// - fixed counter runs only with its bit 22 and the global enable set.
// - fixed counter value in bits 43:0, bits 63:44 reserved.
// - code 0x42 counts received interrupt messages, one per cycle at most.
// - message subevent bits: wire, signalled, interprocessor, bell, priority.
// - code 0x44 counts lock sequence starts, one per cycle at most.
// - programmable counter collects only while its local enable is set.
// - after reset every counter stays disabled until software enables it.
// - no box-wide freeze; counting starts once enabled with valid code.
`timescale 1ns/1ps
module ucfg_event_counters #(
   parameter int CNT_W = 44  // data counter width
) (
   input  wire logic        sys_clk,       // fabric_clock, 20 MHz
   input  wire logic        rst,           // async reset, active high
   input  wire logic        msr_wr,        // register write strobe
   input  wire logic        msr_rd,        // register read strobe
   input  wire logic [15:0] msr_addr,      // register address
   input  wire logic [63:0] msr_wdata,     // write data
   output logic      [63:0] msr_rdata,     // read data, registered
   output logic             msr_rd_valid,  // read data valid pulse
   output logic             msr_fault,     // unmapped access pulse
   input  wire logic        global_en,     // global enable for fixed counter
   input  wire logic [4:0]  msg_events,    // message received pulses
   input  wire logic        lock_start     // lock sequence start pulse
);
   // ==========================================================
   // parameter check
   generate
      if (CNT_W < 1 || CNT_W > 64) begin : g_bad_width
         $error("counter width must be 1 to 64");
      end
   endgenerate

   typedef struct packed {
      logic [1:0][31:0]      ctl;      // event_counter_control
      logic [1:0][CNT_W-1:0] ctr;      // event_counter_value
      logic                  fix_en;   // cycle_counter_control enable
      logic [CNT_W-1:0]      fctr;     // cycle_counter_value
      logic [63:0]           rdata;    // read data
      logic                  rd_valid; // read answer
      logic                  fault;    // unmapped access
   } ucfg_state_type;

   ucfg_state_type s_reg;
   ucfg_state_type s_next;
   logic [1:0]     adv;

   // ==========================================================
   // helpers
   // index of a programmable control register, or -1
   function automatic int ctl_index(input logic [15:0] a);
      if (a == ucfg_pkg::ADDR_CTL0) begin
         return 0;
      end else if (a == ucfg_pkg::ADDR_CTL1) begin
         return 1;
      end
      return -1;
   endfunction

   // index of a programmable data counter, or -1
   function automatic int ctr_index(input logic [15:0] a);
      if (a == ucfg_pkg::ADDR_CTR0) begin
         return 0;
      end else if (a == ucfg_pkg::ADDR_CTR1) begin
         return 1;
      end
      return -1;
   endfunction

   // true for any mapped address
   function automatic logic addr_mapped(input logic [15:0] a);
      return (ctl_index(a) >= 0) || (ctr_index(a) >= 0) ||
             (a == ucfg_pkg::ADDR_FIX_CTL) || (a == ucfg_pkg::ADDR_FIX_CTR);
   endfunction

   // ==========================================================
   // event qualifiers, one per programmable counter
   ucfg_qual_if qif [1:0] ();

   generate
      for (genvar gi = 0; gi < 2; gi++) begin : g_qual
         assign qif[gi].ctl     = s_reg.ctl[gi];
         assign qif[gi].msg_ev  = msg_events;
         assign qif[gi].lock_ev = lock_start;
         assign adv[gi]         = qif[gi].adv;
         ucfg_event_qual u_qual (
            .sys_clk (sys_clk),
            .rst     (rst),
            .q       (qif[gi])
         );
      end
   endgenerate

   // ==========================================================
   // next state: counting first, then register writes take over
   always_comb begin
      s_next          = s_reg;
      s_next.rd_valid = 1'b0;
      s_next.fault    = 1'b0;
      // programmable counters wrap silently past the top bit
      for (int i = 0; i < 2; i++) begin
         if (adv[i]) begin
            s_next.ctr[i] = s_reg.ctr[i] + 1'b1;
         end
      end
      // fixed counter needs both enables
      if (s_reg.fix_en && global_en) begin
         s_next.fctr = s_reg.fctr + 1'b1;
      end
      // counter writes and clear bits override counting in the same cycle
      if (msr_wr) begin
         if (ctl_index(msr_addr) >= 0) begin
            // reserved and write-only bits are not stored
            s_next.ctl[ctl_index(msr_addr)] = msr_wdata[31:0] & ucfg_pkg::CTL_RW_MASK;
            if (msr_wdata[ucfg_pkg::CLR_BIT]) begin
               s_next.ctr[ctl_index(msr_addr)] = '0;
            end
         end else if (ctr_index(msr_addr) >= 0) begin
            s_next.ctr[ctr_index(msr_addr)] = msr_wdata[CNT_W-1:0];
         end else if (msr_addr == ucfg_pkg::ADDR_FIX_CTL) begin
            s_next.fix_en = msr_wdata[ucfg_pkg::EN_BIT];
         end else if (msr_addr == ucfg_pkg::ADDR_FIX_CTR) begin
            s_next.fctr = msr_wdata[CNT_W-1:0];
         end
      end
      // reads never disturb counting; answer next cycle
      if (msr_rd) begin
         s_next.rd_valid = 1'b1;
         s_next.rdata    = 64'h0000000000000000;
         if (ctl_index(msr_addr) >= 0) begin
            s_next.rdata = 64'(s_reg.ctl[ctl_index(msr_addr)]);
         end else if (ctr_index(msr_addr) >= 0) begin
            s_next.rdata = 64'(s_reg.ctr[ctr_index(msr_addr)]);
         end else if (msr_addr == ucfg_pkg::ADDR_FIX_CTL) begin
            s_next.rdata = 64'(ucfg_pkg::FIX_CTL_RW_MASK & {9'h000, s_reg.fix_en, 22'h000000});
         end else if (msr_addr == ucfg_pkg::ADDR_FIX_CTR) begin
            s_next.rdata = 64'(s_reg.fctr);
         end
      end
      // unmapped accesses are flagged; an unmapped read still answers zero with valid set
      if ((msr_rd || msr_wr) && !addr_mapped(msr_addr)) begin
         s_next.fault = 1'b1;
      end
   end

   // ==========================================================
   // state register; everything disabled after reset
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s_reg.ctl      <= {ucfg_pkg::CTL_RESET, ucfg_pkg::CTL_RESET};
         s_reg.ctr      <= '0;
         s_reg.fix_en   <= 1'b0;
         s_reg.fctr     <= '0;
         s_reg.rdata    <= ucfg_pkg::CTR_RESET;
         s_reg.rd_valid <= 1'b0;
         s_reg.fault    <= 1'b0;
      end else begin
         s_reg <= s_next;
      end
   end

   // ==========================================================
   // outputs
   assign msr_rdata    = s_reg.rdata;
   assign msr_rd_valid = s_reg.rd_valid;
   assign msr_fault    = s_reg.fault;

   // ==========================================================
   // checks
   property p_clear;
      @(posedge sys_clk) disable iff (rst)
      (msr_wr && ctl_index(msr_addr) == 0 && msr_wdata[ucfg_pkg::CLR_BIT]) |=>
         (s_reg.ctr[0] == '0);
   endproperty
   a_clear: assert property (p_clear) else $error("clear bit did not zero counter");

   property p_wrap;
      @(posedge sys_clk) disable iff (rst)
      (adv[1] && (&s_reg.ctr[1]) && !msr_wr) |=> (s_reg.ctr[1] == '0);
   endproperty
   a_wrap: assert property (p_wrap) else $error("counter did not wrap");

   property p_fix_run;
      @(posedge sys_clk) disable iff (rst)
      (s_reg.fix_en && global_en && !msr_wr) |=> (s_reg.fctr == $past(s_reg.fctr) + 1'b1);
   endproperty
   a_fix_run: assert property (p_fix_run) else $error("fixed counter missed a cycle");

   property p_fix_hold;
      @(posedge sys_clk) disable iff (rst)
      (!(s_reg.fix_en && global_en) && !msr_wr) |=> $stable(s_reg.fctr);
   endproperty
   a_fix_hold: assert property (p_fix_hold) else $error("fixed counter ran disabled");

   property p_en_gate;
      @(posedge sys_clk) disable iff (rst)
      (!s_reg.ctl[0][ucfg_pkg::EN_BIT] && !msr_wr) |=> $stable(s_reg.ctr[0]);
   endproperty
   a_en_gate: assert property (p_en_gate) else $error("disabled counter moved");

   property p_step_one;
      @(posedge sys_clk) disable iff (rst)
      (!msr_wr) |=> (s_reg.ctr[0] == $past(s_reg.ctr[0]) + CNT_W'($past(adv[0])));
   endproperty
   a_step_one: assert property (p_step_one) else $error("counter step not one");

   property p_read_ctl;
      @(posedge sys_clk) disable iff (rst)
      (msr_rd && ctl_index(msr_addr) >= 0) |=>
         (msr_rd_valid && (msr_rdata & ~64'(ucfg_pkg::CTL_RW_MASK)) == 64'h0000000000000000);
   endproperty
   a_read_ctl: assert property (p_read_ctl) else $error("reserved control bits set");

   property p_read_ctr;
      @(posedge sys_clk) disable iff (rst)
      (msr_rd && ctr_index(msr_addr) == 1) |=>
         (msr_rd_valid && msr_rdata == 64'($past(s_reg.ctr[1])));
   endproperty
   a_read_ctr: assert property (p_read_ctr) else $error("counter read wrong");

   property p_code_gate;
      @(posedge sys_clk) disable iff (rst)
      (s_reg.ctl[1][ucfg_pkg::EVSEL_MSB:ucfg_pkg::EVSEL_LSB] == 8'h00) |-> !adv[1];
   endproperty
   a_code_gate: assert property (p_code_gate) else $error("counted with code zero");

   property p_reset_off;
      @(posedge sys_clk) disable iff (rst)
      ($rose(s_reg.fix_en)) |-> $past(msr_wr && msr_addr == ucfg_pkg::ADDR_FIX_CTL);
   endproperty
   a_reset_off: assert property (p_reset_off) else $error("enable rose without write");

   property p_clear_one;
      @(posedge sys_clk) disable iff (rst)
      (msr_wr && ctl_index(msr_addr) == 1 && msr_wdata[ucfg_pkg::CLR_BIT]) |=>
         (s_reg.ctr[1] == '0);
   endproperty
   a_clear_one: assert property (p_clear_one) else $error("counter one not cleared");

   property p_ctr_write;
      @(posedge sys_clk) disable iff (rst)
      (msr_wr && ctr_index(msr_addr) == 1) |=>
         (s_reg.ctr[1] == $past(msr_wdata[CNT_W-1:0]));
   endproperty
   a_ctr_write: assert property (p_ctr_write) else $error("counter write lost");

   property p_ctr_upper;
      @(posedge sys_clk) disable iff (rst)
      (msr_rd && ctr_index(msr_addr) >= 0) |=>
         ((msr_rdata >> CNT_W) == 64'h0000000000000000);
   endproperty
   a_ctr_upper: assert property (p_ctr_upper) else $error("counter upper bits set");

   property p_fix_upper;
      @(posedge sys_clk) disable iff (rst)
      (msr_rd && msr_addr == ucfg_pkg::ADDR_FIX_CTR) |=>
         ((msr_rdata >> CNT_W) == 64'h0000000000000000);
   endproperty
   a_fix_upper: assert property (p_fix_upper) else $error("fixed upper bits set");

   property p_fix_write;
      @(posedge sys_clk) disable iff (rst)
      (msr_wr && msr_addr == ucfg_pkg::ADDR_FIX_CTR) |=>
         (s_reg.fctr == $past(msr_wdata[CNT_W-1:0]));
   endproperty
   a_fix_write: assert property (p_fix_write) else $error("fixed counter write lost");

   property p_fix_ctl_rd;
      @(posedge sys_clk) disable iff (rst)
      (msr_rd && msr_addr == ucfg_pkg::ADDR_FIX_CTL) |=>
         ((msr_rdata & ~64'(ucfg_pkg::FIX_CTL_RW_MASK)) == 64'h0000000000000000);
   endproperty
   a_fix_ctl_rd: assert property (p_fix_ctl_rd) else $error("fixed control bits set");

   property p_rd_answer;
      @(posedge sys_clk) disable iff (rst)
      msr_rd |=> msr_rd_valid;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read not answered");

   // ==========================================================
   // scenarios of interest
   c_msg_count: cover property (@(posedge sys_clk) disable iff (rst)
      adv[0] && s_reg.ctl[0][7:0] == ucfg_pkg::EV_LEGACY_WIRE_MESSAGES);
   c_lock_count: cover property (@(posedge sys_clk) disable iff (rst)
      adv[1] && s_reg.ctl[1][7:0] == ucfg_pkg::EV_LOCK_STARTS);
   c_wrap: cover property (@(posedge sys_clk) disable iff (rst)
      adv[0] && (&s_reg.ctr[0]));
   c_fix_read: cover property (@(posedge sys_clk) disable iff (rst)
      msr_rd && msr_addr == ucfg_pkg::ADDR_FIX_CTR && s_reg.fix_en && global_en);
   c_fall_edge: cover property (@(posedge sys_clk) disable iff (rst)
      adv[0] && s_reg.ctl[0][ucfg_pkg::EDGE_BIT] && s_reg.ctl[0][ucfg_pkg::INVERT_BIT]);
endmodule

// file: verilog/ucfg_event_qual.sv
// event selection, threshold, invert and edge shaping for one counter
`timescale 1ns/1ps
module ucfg_event_qual (
   input wire logic   sys_clk,  // fabric_clock
   input wire logic   rst,      // async reset, active high
   ucfg_qual_if.qual  q         // control and events in, advance out
);
   typedef struct packed {
      logic prev_ge;  // threshold compare result last cycle
   } ucfg_qstate_type;

   ucfg_qstate_type s_reg;
   ucfg_qstate_type s_next;
   logic [7:0]      evsel;
   logic [7:0]      umask;
   logic [4:0]      thresh;
   logic [4:0]      inc;
   logic            code_ok;
   logic            ge;
   logic            hit;

   // ==========================================================
   // decode, threshold compare and shaping
   always_comb begin
      evsel   = q.ctl[ucfg_pkg::EVSEL_MSB:ucfg_pkg::EVSEL_LSB];
      umask   = q.ctl[ucfg_pkg::UMASK_MSB:ucfg_pkg::UMASK_LSB];
      thresh  = q.ctl[ucfg_pkg::THRESH_MSB:ucfg_pkg::THRESH_LSB];
      inc     = 5'h00;
      code_ok = 1'b0;
      case (evsel)
         ucfg_pkg::EV_LEGACY_WIRE_MESSAGES: begin
            inc     = {4'h0, |(q.msg_ev & umask[4:0])};
            code_ok = 1'b1;
         end
         ucfg_pkg::EV_LOCK_STARTS: begin
            inc     = {4'h0, q.lock_ev};
            code_ok = 1'b1;
         end
         default: begin
            inc     = 5'h00;
            code_ok = 1'b0;
         end
      endcase
      ge = (inc >= thresh);
      if (q.ctl[ucfg_pkg::EDGE_BIT]) begin
         if (q.ctl[ucfg_pkg::INVERT_BIT]) begin
            hit = s_reg.prev_ge & ~ge;
         end else begin
            hit = ~s_reg.prev_ge & ge;
         end
      end else begin
         hit = q.ctl[ucfg_pkg::INVERT_BIT] ? ~ge : ge;
      end
      // one count per qualifying cycle or transition
      q.adv          = q.ctl[ucfg_pkg::EN_BIT] & code_ok & hit;
      s_next.prev_ge = ge;
   end

   // ==========================================================
   // state register
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // ==========================================================
   // checks on the shaping
   property p_rise_only;
      @(posedge sys_clk) disable iff (rst)
      (q.adv && q.ctl[ucfg_pkg::EDGE_BIT] && !q.ctl[ucfg_pkg::INVERT_BIT]) |->
         (ge && !s_reg.prev_ge);
   endproperty
   a_rise_only: assert property (p_rise_only) else $error("edge count without rise");

   property p_fall_only;
      @(posedge sys_clk) disable iff (rst)
      (q.adv && q.ctl[ucfg_pkg::EDGE_BIT] && q.ctl[ucfg_pkg::INVERT_BIT]) |->
         (!ge && s_reg.prev_ge);
   endproperty
   a_fall_only: assert property (p_fall_only) else $error("edge count without fall");

   property p_thresh;
      @(posedge sys_clk) disable iff (rst)
      (q.adv && !q.ctl[ucfg_pkg::EDGE_BIT]) |-> ((inc >= thresh) != q.ctl[ucfg_pkg::INVERT_BIT]);
   endproperty
   a_thresh: assert property (p_thresh) else $error("advance against threshold");
endmodule

// file: verilog/ucfg_pkg.sv
// constants shared by the configuration unit event counters
package ucfg_pkg;

   // ==========================================================
   // register addresses, as seen on the register access port
   localparam logic [15:0] ADDR_FIX_CTL = 16'h0C08;  // cycle_counter_control
   localparam logic [15:0] ADDR_FIX_CTR = 16'h0C09;  // cycle_counter_value
   localparam logic [15:0] ADDR_CTL0    = 16'h0C10;  // event_counter_control 0
   localparam logic [15:0] ADDR_CTL1    = 16'h0C11;  // event_counter_control 1
   localparam logic [15:0] ADDR_CTR0    = 16'h0C16;  // event_counter_value 0
   localparam logic [15:0] ADDR_CTR1    = 16'h0C17;  // event_counter_value 1

   // ==========================================================
   // control register field positions
   localparam int THRESH_LSB = 24;
   localparam int THRESH_MSB = 28;
   localparam int INVERT_BIT = 23;
   localparam int EN_BIT     = 22;
   localparam int EDGE_BIT   = 18;
   localparam int CLR_BIT    = 17;
   localparam int UMASK_LSB  = 8;
   localparam int UMASK_MSB  = 15;
   localparam int EVSEL_LSB  = 0;
   localparam int EVSEL_MSB  = 7;

   // writable bits of each control register, the rest read zero
   localparam logic [31:0] CTL_RW_MASK     = 32'h1FC4FFFF;
   localparam logic [31:0] FIX_CTL_RW_MASK = 32'h00400000;

   // ==========================================================
   // values after reset
   localparam logic [31:0] CTL_RESET = 32'h00000000;
   localparam logic [63:0] CTR_RESET = 64'h0000000000000000;

   // ==========================================================
   // event codes and message subevent bits
   localparam logic [7:0] EV_LEGACY_WIRE_MESSAGES = 8'h42;
   localparam logic [7:0] EV_LOCK_STARTS          = 8'h44;
   localparam int UM_VIRTUAL_WIRE     = 0;  // virtual_wire_received
   localparam int UM_SIGNALLED_IRQ    = 1;  // signalled_irq_received
   localparam int UM_INTERPROC_IRQ    = 2;  // interprocessor_irq_received
   localparam int UM_BELL_MSG         = 3;  // bell_msg_received
   localparam int UM_IRQ_PRIORITY     = 4;  // irq_priority_update
   localparam int MSG_W               = 5;
   localparam int THRESH_W            = 5;
   localparam int NUM_CTR             = 2;

endpackage

// file: verilog/ucfg_qual_if.sv
// carrier between the counter top and one event qualifier
`timescale 1ns/1ps
interface ucfg_qual_if;
   logic [31:0] ctl;      // control register contents
   logic [4:0]  msg_ev;   // message event pulses
   logic        lock_ev;  // lock sequence start pulse
   logic        adv;      // counter advances this cycle

   modport top  (output ctl, output msg_ev, output lock_ev, input adv);
   modport qual (input ctl, input msg_ev, input lock_ev, output adv);
endinterface
